/* core/ifr_flag_status.sv */
// Purpose: Interrupt flag status register, second of a bank
// Assumes: Event sources run on clk; bus is Avalon-MM with waitrequest
// Notes: Flags are plain read/write; a second sticky status gives an irq line
`timescale 1ns/1ns
module ifr_flag_status
    import ifr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_WIDTH-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [BUS_WIDTH-1:0] writedata,
    input wire logic [BE_WIDTH-1:0] byteenable,
    output logic [BUS_WIDTH-1:0] readdata,
    output logic waitrequest,
    input wire ifr_sources_type sources,
    output logic [FLAG_WIDTH-1:0] flags,
    output logic irq
);

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    logic capture;
    logic accept;

    ifr_avalon_slave u_slave (
        .clk(clk),
        .rst(rst),
        .read(read),
        .write(write),
        .waitrequest(waitrequest),
        .capture(capture),
        .accept(accept)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic writeAccept;
    logic hitFlags;
    logic hitIrqStatus;
    logic hitIrqMask;
    logic hitRawSources;
    logic [FLAG_WIDTH-1:0] laneMask;
    logic [FLAG_WIDTH-1:0] sourceVec;
    logic [FLAG_WIDTH-1:0] setVec;

    assign writeAccept = accept & write;
    assign hitFlags = (address == OFFSET_FLAGS);
    assign hitIrqStatus = (address == OFFSET_IRQ_STATUS);
    assign hitIrqMask = (address == OFFSET_IRQ_MASK);
    assign hitRawSources = (address == OFFSET_RAW_SOURCES);
    // Byte lanes above the low two carry nothing here
    assign laneMask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
    // Mapped bit by bit so the flag layout does not hang on the struct order
    always_comb begin
        sourceVec = '0;
        sourceVec[BIT_UART_B_TRANSMIT] = sources.uartBTransmit;
        sourceVec[BIT_UART_B_RECEIVE] = sources.uartBReceive;
        sourceVec[BIT_EXTERNAL_IRQ_TWO] = sources.externalIrqTwo;
        sourceVec[BIT_TIMER_FIVE] = sources.timerFive;
        sourceVec[BIT_TIMER_FOUR] = sources.timerFour;
        sourceVec[BIT_COMPARE_OUT_FOUR] = sources.compareOutFour;
        sourceVec[BIT_COMPARE_OUT_THREE] = sources.compareOutThree;
        sourceVec[BIT_CAPTURE_IN_EIGHT] = sources.captureInEight;
        sourceVec[BIT_CAPTURE_IN_SEVEN] = sources.captureInSeven;
        sourceVec[BIT_EXTERNAL_IRQ_ONE] = sources.externalIrqOne;
        sourceVec[BIT_PIN_CHANGE] = sources.pinChange;
        sourceVec[BIT_COMPARATOR_EVENT] = sources.comparatorEvent;
        sourceVec[BIT_I2C_A_MASTER] = sources.i2cAMasterEvent;
        sourceVec[BIT_I2C_A_SLAVE] = sources.i2cASlaveEvent;
    end
    // Requests on the spare positions are dropped here
    assign setVec = sourceVec & IMPL_MASK;

    // ------------------------------------------------------------
    // Flag bits
    // ------------------------------------------------------------
    logic [FLAG_WIDTH-1:0] flagVec;

    genvar i;
    generate
        for (i = 0; i < FLAG_WIDTH; i++) begin : g_flag
            // Cells at the spare positions are built as constant zero
            ifr_flag_cell #(
                .IMPLEMENTED(IMPL_MASK[i])
            ) u_cell (
                .clk(clk),
                .rst(rst),
                .setReq(setVec[i]),
                .writeEn(writeAccept & hitFlags & laneMask[i]),
                .writeValue(writedata[i]),
                .flag(flagVec[i])
            );
        end
    endgenerate

    assign flags = flagVec;

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic [FLAG_WIDTH-1:0] irqStatus_reg;
    logic [FLAG_WIDTH-1:0] irqStatus_next;
    logic [FLAG_WIDTH-1:0] irqMask_reg;
    logic [FLAG_WIDTH-1:0] irqClear;
    logic irq_reg;

    assign irqClear = (writeAccept & hitIrqStatus) ? (writedata[FLAG_WIDTH-1:0] & laneMask) : '0;
    // Set wins over a write-one clear in the same cycle
    assign irqStatus_next = (irqStatus_reg & ~irqClear) | setVec;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqStatus_reg <= IRQ_STATUS_RESET;
        end else begin
            irqStatus_reg <= irqStatus_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqMask_reg <= IRQ_MASK_RESET;
        end else if (writeAccept && hitIrqMask) begin
            irqMask_reg <= ((irqMask_reg & ~laneMask) | (writedata[FLAG_WIDTH-1:0] & laneMask)) & IMPL_MASK;
        end
    end

    // Registered so the line never glitches during a bus write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irqStatus_next & irqMask_reg);
        end
    end

    assign irq = irq_reg;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [BUS_WIDTH-1:0] readdata_reg;
    logic [FLAG_WIDTH-1:0] readSel;

    always_comb begin
        readSel = '0;
        if (hitFlags) begin
            readSel = flagVec & IMPL_MASK;
        end else if (hitIrqStatus) begin
            readSel = irqStatus_reg;
        end else if (hitIrqMask) begin
            readSel = irqMask_reg;
        end else if (hitRawSources) begin
            readSel = setVec;
        end
    end

    // Loaded in the wait state so data stand at the accepting edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata_reg <= '0;
        end else if (capture && read) begin
            readdata_reg <= {{(BUS_WIDTH-FLAG_WIDTH){1'b0}}, readSel};
        end
    end

    assign readdata = readdata_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_flag_hold_idle: assert property (
        (setVec == '0 && !(writeAccept && hitFlags)) |=> (flagVec == $past(flagVec))
    ) else $error("flag changed with no event and no write");

    a_flag_set_event: assert property (
        (setVec != '0) |=> ((flagVec & $past(setVec)) == $past(setVec))
    ) else $error("requested flag not set");

    a_spare_bits_zero: assert property (
        (flagVec[BIT_UNUSED_HIGH] == 1'b0) && (flagVec[BIT_UNUSED_LOW] == 1'b0)
            && !(readdata[BIT_UNUSED_HIGH] || readdata[BIT_UNUSED_LOW])
    ) else $error("spare flag position not zero");

    a_ext_one_bit: assert property (
        sources.externalIrqOne |=> flagVec[BIT_EXTERNAL_IRQ_ONE] && irqStatus_reg[BIT_EXTERNAL_IRQ_ONE]
    ) else $error("external irq one flag missing");

    a_pin_change_bit: assert property (
        sources.pinChange |=> flagVec[BIT_PIN_CHANGE]
    ) else $error("pin change flag missing");

    a_comparator_bit: assert property (
        sources.comparatorEvent |=> flagVec[BIT_COMPARATOR_EVENT]
    ) else $error("comparator flag missing");

    a_i2c_master_bit: assert property (
        sources.i2cAMasterEvent |=> flagVec[BIT_I2C_A_MASTER]
    ) else $error("i2c master flag missing");

    a_i2c_slave_bit: assert property (
        sources.i2cASlaveEvent |=> flagVec[BIT_I2C_A_SLAVE]
    ) else $error("i2c slave flag missing");

    a_sw_clear_zero: assert property (
        (writeAccept && hitFlags && byteenable[1:0] == 2'h3 && writedata[15:0] == 16'h0000 && setVec == '0)
            |=> (flagVec == 16'h0000)
    ) else $error("write of zero did not clear flags");

    a_sw_write_set: assert property (
        (writeAccept && hitFlags && byteenable[1:0] == 2'h3)
            |=> ((flagVec & ~$past(setVec)) == ($past(writedata[15:0]) & IMPL_MASK & ~$past(setVec)))
    ) else $error("written flag value not stored");

    a_upper_map: assert property (
        (sources.uartBTransmit && sources.captureInSeven && sources.compareOutThree)
            |=> (flagVec[BIT_UART_B_TRANSMIT] && flagVec[BIT_CAPTURE_IN_SEVEN] && flagVec[BIT_COMPARE_OUT_THREE])
    ) else $error("upper flag mapping wrong");

    a_one_wait_state: assert property (
        ((read || write) && waitrequest) ##1 ($stable(read) && $stable(write) && (read || write)) |-> !waitrequest
    ) else $error("wait state longer than one cycle");

    a_read_flags_data: assert property (
        (capture && read && hitFlags && !writeAccept && setVec == '0)
            |=> (readdata[15:0] == (flagVec & IMPL_MASK)) && (readdata[31:16] == 16'h0000)
    ) else $error("flag read data wrong");

    a_irq_follows: assert property (
        ((irqStatus_reg & irqMask_reg) != '0) ##1 ((irqStatus_reg & irqMask_reg) != '0) |-> irq
    ) else $error("irq low with unmasked status set");

    a_uart_tx_bit: assert property (
        sources.uartBTransmit |=> flagVec[BIT_UART_B_TRANSMIT]
    ) else $error("uart b transmit flag missing");

    a_uart_rx_bit: assert property (
        sources.uartBReceive |=> flagVec[BIT_UART_B_RECEIVE]
    ) else $error("uart b receive flag missing");

    a_irq_two_bit: assert property (
        sources.externalIrqTwo |=> flagVec[BIT_EXTERNAL_IRQ_TWO]
    ) else $error("external irq two flag missing");

    a_timer_five_bit: assert property (
        sources.timerFive |=> flagVec[BIT_TIMER_FIVE]
    ) else $error("timer five flag missing");

    a_timer_four_bit: assert property (
        sources.timerFour |=> flagVec[BIT_TIMER_FOUR]
    ) else $error("timer four flag missing");

    a_compare_four_bit: assert property (
        sources.compareOutFour |=> flagVec[BIT_COMPARE_OUT_FOUR]
    ) else $error("compare four flag missing");

    a_compare_three_bit: assert property (
        sources.compareOutThree |=> flagVec[BIT_COMPARE_OUT_THREE]
    ) else $error("compare three flag missing");

    a_capture_eight_bit: assert property (
        sources.captureInEight |=> flagVec[BIT_CAPTURE_IN_EIGHT]
    ) else $error("capture eight flag missing");

    a_capture_seven_bit: assert property (
        sources.captureInSeven |=> flagVec[BIT_CAPTURE_IN_SEVEN]
    ) else $error("capture seven flag missing");

    a_status_set_event: assert property (
        (setVec != '0) |=> ((irqStatus_reg & $past(setVec)) == $past(setVec))
    ) else $error("status bit not set by event");

    a_status_w1c_clear: assert property (
        (writeAccept && hitIrqStatus && byteenable[1:0] == 2'h3 && setVec == '0)
            |=> ((irqStatus_reg & $past(writedata[15:0])) == '0)
    ) else $error("status bit not cleared by write of one");

    a_status_sticky: assert property (
        (setVec == '0 && !(writeAccept && hitIrqStatus))
            |=> (irqStatus_reg == $past(irqStatus_reg))
    ) else $error("status changed with no event and no clear");

    a_status_spare_zero: assert property (
        ((irqStatus_reg | irqMask_reg) & ~IMPL_MASK) == '0
    ) else $error("spare status or mask bit set");

    a_mask_write: assert property (
        (writeAccept && hitIrqMask && byteenable[1:0] == 2'h3)
            |=> (irqMask_reg == ($past(writedata[15:0]) & IMPL_MASK))
    ) else $error("mask write not stored");

    a_mask_hold: assert property (
        !(writeAccept && hitIrqMask) |=> $stable(irqMask_reg)
    ) else $error("mask changed with no write");

    a_irq_quiet: assert property (
        ((irqStatus_reg & irqMask_reg) == '0 && setVec == '0) ##1 ((irqStatus_reg & irqMask_reg) == '0)
            |-> !irq
    ) else $error("irq high with no unmasked status");

    a_wait_first: assert property (
        $rose(read || write) |-> waitrequest
    ) else $error("new request not held in wait state");

    a_single_accept: assert property (
        accept |=> !accept
    ) else $error("request accepted twice");

    a_lane_low_only: assert property (
        (writeAccept && hitFlags && byteenable[1:0] == 2'h1 && setVec == '0)
            |=> (flagVec[15:8] == $past(flagVec[15:8]))
    ) else $error("disabled high lane written");

    a_lane_high_only: assert property (
        (writeAccept && hitFlags && byteenable[1:0] == 2'h2 && setVec == '0)
            |=> (flagVec[7:0] == $past(flagVec[7:0]))
    ) else $error("disabled low lane written");

    a_read_status_data: assert property (
        (capture && read && hitIrqStatus && setVec == '0)
            |=> (readdata[15:0] == irqStatus_reg)
    ) else $error("status read data wrong");

    a_read_mask_data: assert property (
        (capture && read && hitIrqMask) |=> (readdata[15:0] == irqMask_reg)
    ) else $error("mask read data wrong");

    a_unmapped_read_zero: assert property (
        (capture && read && !(hitFlags || hitIrqStatus || hitIrqMask || hitRawSources))
            |=> (readdata == '0)
    ) else $error("unmapped read not zero");

endmodule : ifr_flag_status

/* core/ifr_pkg.sv */
// Purpose: Shared constants and types for the interrupt flag status block
// Assumes: 25 MHz system clock, Avalon-MM slave with 32-bit data
// Notes: Byte addresses, one register per aligned word
package ifr_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int FLAG_WIDTH = 16;
    localparam int BUS_WIDTH = 32;
    localparam int ADDR_WIDTH = 5;
    localparam int BE_WIDTH = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_WIDTH-1:0] OFFSET_FLAGS = 5'h00;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_IRQ_STATUS = 5'h04;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_IRQ_MASK = 5'h08;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_RAW_SOURCES = 5'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_UART_B_TRANSMIT = 15;
    localparam int BIT_UART_B_RECEIVE = 14;
    localparam int BIT_EXTERNAL_IRQ_TWO = 13;
    localparam int BIT_TIMER_FIVE = 12;
    localparam int BIT_TIMER_FOUR = 11;
    localparam int BIT_COMPARE_OUT_FOUR = 10;
    localparam int BIT_COMPARE_OUT_THREE = 9;
    localparam int BIT_UNUSED_HIGH = 8;
    localparam int BIT_CAPTURE_IN_EIGHT = 7;
    localparam int BIT_CAPTURE_IN_SEVEN = 6;
    localparam int BIT_UNUSED_LOW = 5;
    localparam int BIT_EXTERNAL_IRQ_ONE = 4;
    localparam int BIT_PIN_CHANGE = 3;
    localparam int BIT_COMPARATOR_EVENT = 2;
    localparam int BIT_I2C_A_MASTER = 1;
    localparam int BIT_I2C_A_SLAVE = 0;

    // ------------------------------------------------------------
    // Implemented bits and reset values
    // ------------------------------------------------------------
    localparam logic [FLAG_WIDTH-1:0] IMPL_MASK = 16'hfedf;
    localparam logic [FLAG_WIDTH-1:0] FLAGS_RESET = 16'h0000;
    localparam logic [FLAG_WIDTH-1:0] IRQ_STATUS_RESET = 16'h0000;
    localparam logic [FLAG_WIDTH-1:0] IRQ_MASK_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Event sources, one request line per flag position
    // ------------------------------------------------------------
    typedef struct packed {
        logic uartBTransmit;
        logic uartBReceive;
        logic externalIrqTwo;
        logic timerFive;
        logic timerFour;
        logic compareOutFour;
        logic compareOutThree;
        logic spareHigh;
        logic captureInEight;
        logic captureInSeven;
        logic spareLow;
        logic externalIrqOne;
        logic pinChange;
        logic comparatorEvent;
        logic i2cAMasterEvent;
        logic i2cASlaveEvent;
    } ifr_sources_type;

endpackage : ifr_pkg

/* core/ifr_flag_cell.sv */
// Purpose: One hardware settable flag bit with software write access
// Assumes: Set request comes from logic on the same clock
// Notes: An unimplemented cell is a constant zero
`timescale 1ns/1ns
module ifr_flag_cell #(
    parameter bit IMPLEMENTED = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic setReq,
    input wire logic writeEn,
    input wire logic writeValue,
    output logic flag
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic flag_reg;
    logic flag_next;

    generate
        if (IMPLEMENTED) begin : g_impl
            // Set beats a same-cycle software clear, so no event is lost
            always_comb begin
                flag_next = flag_reg;
                if (setReq) begin
                    flag_next = 1'b1;
                end else if (writeEn) begin
                    flag_next = writeValue;
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    flag_reg <= 1'b0;
                end else begin
                    flag_reg <= flag_next;
                end
            end
        end else begin : g_none
            assign flag_next = 1'b0;
            assign flag_reg = 1'b0;
        end
    endgenerate

    assign flag = flag_reg;

endmodule : ifr_flag_cell

/* core/ifr_avalon_slave.sv */
// Purpose: Avalon-MM handshake with one fixed wait state
// Assumes: Master holds its request until waitrequest is low
// Notes: capture pulses one cycle before accept
`timescale 1ns/1ns
module ifr_avalon_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic read,
    input wire logic write,
    output logic waitrequest,
    output logic capture,
    output logic accept
);

    // ------------------------------------------------------------
    // Wait state
    // ------------------------------------------------------------
    logic request;
    logic ack_reg;

    assign request = read | write;
    assign capture = request & ~ack_reg;
    assign accept = request & ack_reg;
    // One wait state leaves a full cycle to register read data
    assign waitrequest = request & ~ack_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= capture;
        end
    end

endmodule : ifr_avalon_slave

/* bench/ifr_event_model.sv */
// Purpose: Behavioural model of the peripheral event sources
// Assumes: Events are launched on clk by the bench
// Notes: Idle sources drive zero; hold keeps a level high like a slow source
`timescale 1ns/1ns
module ifr_event_model
    import ifr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic fireGo,
    input wire logic holdLevel,
    input wire logic [FLAG_WIDTH-1:0] fireVec,
    output ifr_sources_type sources
);
    // ------------------------------------------------------------
    // Event launch
    // ------------------------------------------------------------
    // One-cycle pulse by default, so a stuck set path shows up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sources <= '0;
        end else if (fireGo || holdLevel) begin
            sources <= ifr_sources_type'(fireVec);
        end else begin
            sources <= '0;
        end
    end
endmodule : ifr_event_model

/* bench/testbench.sv */
// Purpose: Self-checking bench for the interrupt flag status block
// Assumes: Avalon tasks are entered right after a rising edge
// Notes: Tasks leave the request up; settle drops it before idle time
`timescale 1ns/1ns
module testbench
    import ifr_pkg::*;
;
    logic clk, rst, read, write, waitrequest, irq, fireGo, holdLevel;
    logic [ADDR_WIDTH-1:0] address;
    logic [BUS_WIDTH-1:0] writedata, readdata, rdVal;
    logic [BE_WIDTH-1:0] byteenable;
    logic [FLAG_WIDTH-1:0] flags, fireVec;
    ifr_sources_type sources;
    int fails, checksDone;

    ifr_flag_status u_ifr_flag_status (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .sources(sources), .flags(flags), .irq(irq));
    ifr_event_model u_ifr_event_model (.clk(clk), .rst(rst), .fireGo(fireGo), .holdLevel(holdLevel),
        .fireVec(fireVec), .sources(sources));

    always #20 clk = ~clk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Request stands until the edge that samples waitrequest low; read data taken there
    task automatic access(input logic wr, input logic [4:0] addr, input logic [31:0] data, input logic [3:0] be);
        address <= addr;
        read <= !wr;
        write <= wr;
        writedata <= data;
        byteenable <= be;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        if (!wr) begin
            rdVal = readdata;
        end
    endtask : access

    task automatic reg_write(input logic [4:0] addr, input logic [31:0] data);
        access(1'b1, addr, data, 4'h3);
    endtask : reg_write

    task automatic reg_read(input logic [4:0] addr);
        access(1'b0, addr, 32'h0, 4'h3);
    endtask : reg_read

    task automatic settle(input int n);
        read <= 1'b0;
        write <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : settle

    task automatic fire(input logic [15:0] vec);
        read <= 1'b0;
        write <= 1'b0;
        fireVec <= vec;
        fireGo <= 1'b1;
        @(posedge clk);
        fireGo <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : fire

    task automatic named_case(input ifr_sources_type ev, input logic [15:0] exp);
        fire(16'(ev));
        check("named flag", 32'(flags), 32'(exp));
        reg_write(OFFSET_FLAGS, 32'h0);
    endtask : named_case

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        clk = 0;
        rst = 1;
        {read, write, fireGo, holdLevel} = '0;
        address = '0;
        writedata = '0;
        byteenable = '0;
        fireVec = '0;
        fails = 0;
        checksDone = 0;
        repeat (6) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        check("flags port", 32'(flags), 32'(FLAGS_RESET));
        check("irq", 32'(irq), 32'h0);
        reg_read(OFFSET_FLAGS);
        check("flags reg", rdVal, 32'(FLAGS_RESET));
        reg_read(OFFSET_IRQ_STATUS);
        check("irq status", rdVal, 32'(IRQ_STATUS_RESET));
        reg_read(OFFSET_IRQ_MASK);
        check("irq mask", rdVal, 32'(IRQ_MASK_RESET));
        $display("test reset_values done");
        // Every position, spares included
        for (int i = 0; i < FLAG_WIDTH; i++) begin
            fire(16'h0001 << i);
            check("flags port", 32'(flags), 32'(IMPL_MASK & (16'h0001 << i)));
            reg_read(OFFSET_FLAGS);
            check("flags reg", rdVal, 32'(IMPL_MASK & (16'h0001 << i)));
            reg_write(OFFSET_FLAGS, 32'h0);
            reg_read(OFFSET_FLAGS);
            check("flags cleared", rdVal, 32'h0);
        end
        named_case('{externalIrqOne: 1'b1, default: 1'b0}, 16'h0010);
        named_case('{pinChange: 1'b1, default: 1'b0}, 16'h0008);
        named_case('{comparatorEvent: 1'b1, default: 1'b0}, 16'h0004);
        named_case('{i2cAMasterEvent: 1'b1, default: 1'b0}, 16'h0002);
        named_case('{i2cASlaveEvent: 1'b1, default: 1'b0}, 16'h0001);
        // Bits 15, 9 and 6 in one cycle
        fire(16'h8240);
        check("upper map", 32'(flags), 32'h00008240);
        reg_write(OFFSET_FLAGS, 32'h0);
        $display("test event_sources done");
        reg_write(OFFSET_FLAGS, 32'h0000ffff);
        reg_read(OFFSET_FLAGS);
        check("flags all ones", rdVal, 32'h0000fedf);
        access(1'b1, OFFSET_FLAGS, 32'h0, 4'h1);
        reg_read(OFFSET_FLAGS);
        check("low lane clear", rdVal, 32'h0000fe00);
        reg_write(OFFSET_FLAGS, 32'h0);
        access(1'b1, OFFSET_FLAGS, 32'h0000ffff, 4'h2);
        reg_read(OFFSET_FLAGS);
        check("high lane set", rdVal, 32'h0000fe00);
        reg_write(OFFSET_FLAGS, 32'h0);
        settle(1);
        check("flags port", 32'(flags), 32'h0);
        $display("test software_access done");
        // A held source must beat a clearing write
        fireVec <= 16'h0008;
        holdLevel <= 1'b1;
        repeat (3) @(posedge clk);
        reg_read(OFFSET_RAW_SOURCES);
        check("raw sources", rdVal, 32'h00000008);
        reg_write(OFFSET_FLAGS, 32'h0);
        reg_read(OFFSET_FLAGS);
        check("held source", rdVal, 32'h00000008);
        holdLevel <= 1'b0;
        settle(2);
        reg_write(OFFSET_FLAGS, 32'h0);
        reg_read(OFFSET_FLAGS);
        check("released source", rdVal, 32'h0);
        $display("test held_source done");
        reg_write(OFFSET_IRQ_STATUS, 32'h0000ffff);
        reg_write(OFFSET_IRQ_MASK, 32'h0);
        fire(16'h0004);
        check("irq masked", 32'(irq), 32'h0);
        reg_read(OFFSET_IRQ_STATUS);
        check("irq status", rdVal, 32'h00000004);
        reg_write(OFFSET_IRQ_MASK, 32'h00000004);
        reg_read(OFFSET_IRQ_MASK);
        check("irq mask", rdVal, 32'h00000004);
        settle(2);
        check("irq unmasked", 32'(irq), 32'h1);
        reg_write(OFFSET_IRQ_STATUS, 32'h00000004);
        settle(2);
        check("irq cleared", 32'(irq), 32'h0);
        reg_read(OFFSET_IRQ_STATUS);
        check("irq status", rdVal, 32'h0);
        $display("test interrupt done");
        reg_write(5'h10, 32'h0000ffff);
        reg_read(5'h10);
        check("unmapped", rdVal, 32'h0);
        // Comparator flag from the interrupt test is still set
        reg_read(OFFSET_FLAGS);
        check("flags untouched", rdVal, 32'h00000004);
        settle(1);
        $display("test unmapped done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("flags after reset", 32'(flags), 32'(FLAGS_RESET));
        check("irq after reset", 32'(irq), 32'h0);
        reg_read(OFFSET_IRQ_MASK);
        check("mask after reset", rdVal, 32'(IRQ_MASK_RESET));
        $display("test mid_reset done");
        report_and_stop();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        report_and_stop();
    end
endmodule : testbench
